//--- rtl/bitclr_wdt_regs.vh
// Constants for the bit-clear and watchdog-clear execution block
`ifndef BITCLR_WDT_REGS_VH
`define BITCLR_WDT_REGS_VH

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define OP_NONE          3'h0
`define OP_BIT_CLEAR     3'h1
`define OP_WDT_CLEAR     3'h2
`define OP_WDT_PRE_FIRST 3'h3
`define OP_WDT_PRE_SECND 3'h4

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define BYTE_W           8
`define BIT_SEL_W        3
`define WDT_W            8
`define WDT_ZERO         8'h00
`define FLAG_RESET       1'h0
`define FLAG_CLEAR       1'h0

`endif

//--- rtl/bit_clear_unit.v
// Byte bit-clear datapath
`timescale 1ns/1ps
`default_nettype none
`include "bitclr_wdt_regs.vh"

module bit_clear_unit
(
    // Operand
    input  wire [`BYTE_W-1:0]    data_i,
    input  wire [`BIT_SEL_W-1:0] bit_sel_i,
    // Result
    output wire [`BYTE_W-1:0]    data_o
);

    genvar g;
    generate
        for (g = 0; g < `BYTE_W; g = g + 1)
        begin : gen_bit
            // Selected bit forced low, others kept
            assign data_o[g] = (bit_sel_i == g) ? 1'b0 : data_i[g];
        end
    endgenerate

endmodule
`default_nettype wire

//--- rtl/bitclr_wdt_exec.v
// Execution of bit-clear and watchdog-clear instructions
`timescale 1ns/1ps
`default_nettype none
`include "bitclr_wdt_regs.vh"

module bitclr_wdt_exec
(
    // Clock and reset
    input  wire                  sys_clk_i,
    input  wire                  rst_b_i,
    // Decoded instruction
    input  wire                  exec_i,
    input  wire [2:0]            op_i,
    input  wire [`BIT_SEL_W-1:0] bit_sel_i,
    input  wire [`BYTE_W-1:0]    mem_rdata_i,
    // Flag events from the rest of the core
    input  wire                  timeout_set_i,
    input  wire                  powerdown_set_i,
    // Memory write-back
    output reg                   mem_we_o,
    output reg  [`BYTE_W-1:0]    mem_wdata_o,
    // Watchdog and flags
    output reg                   wdt_clear_o,
    output reg                   timeout_flag_o,
    output reg                   powerdown_flag_o,
    output reg                   preclear_pending_o
);

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire [`BYTE_W-1:0] cleared;
    wire do_bitclr = exec_i && (op_i == `OP_BIT_CLEAR);
    wire do_single = exec_i && (op_i == `OP_WDT_CLEAR);
    wire do_first  = exec_i && (op_i == `OP_WDT_PRE_FIRST);
    wire do_second = exec_i && (op_i == `OP_WDT_PRE_SECND);

    // ----------------------------------------
    // Pair tracker states
    // ----------------------------------------
    // One-hot; a repeated half keeps its state, so only the other half clears
    localparam [2:0] PAIR_IDLE   = 3'h1;
    localparam [2:0] PAIR_FIRST  = 3'h2;
    localparam [2:0] PAIR_SECOND = 3'h4;

    reg  [2:0]         pair_state;
    reg  [2:0]         next_pair_state;
    reg                pair_done;
    wire               wdt_clr;
    reg                next_mem_we;
    reg  [`BYTE_W-1:0] next_mem_wdata;
    reg                next_timeout_flag;
    reg                next_powerdown_flag;

    assign wdt_clr = do_single | pair_done;

    bit_clear_unit u_bit_clear
    (
        .data_i    (mem_rdata_i),
        .bit_sel_i (bit_sel_i),
        .data_o    (cleared)
    );

    // ----------------------------------------
    // Memory write-back
    // ----------------------------------------
    // Byte held after the strobe so a slow memory may latch it late
    always @*
    begin
        next_mem_we    = do_bitclr;
        next_mem_wdata = mem_wdata_o;
        if (do_bitclr)
            next_mem_wdata = cleared;
    end

    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mem_we_o    <= 1'b0;
            mem_wdata_o <= {`BYTE_W{1'b0}};
        end
        else
        begin
            mem_we_o    <= next_mem_we;
            mem_wdata_o <= next_mem_wdata;
        end
    end

    // ----------------------------------------
    // Watchdog clear and pair tracking
    // ----------------------------------------
    always @*
    begin
        pair_done       = 1'b0;
        next_pair_state = pair_state;
        case (pair_state)
            PAIR_IDLE:
            begin
                if (do_first)
                    next_pair_state = PAIR_FIRST;
                else if (do_second)
                    next_pair_state = PAIR_SECOND;
            end
            PAIR_FIRST:
            begin
                if (do_second)
                begin
                    pair_done       = 1'b1;
                    next_pair_state = PAIR_IDLE;
                end
            end
            PAIR_SECOND:
            begin
                if (do_first)
                begin
                    pair_done       = 1'b1;
                    next_pair_state = PAIR_IDLE;
                end
            end
            default:
                next_pair_state = PAIR_IDLE;
        endcase
        // Single clear also drops a half-finished pair
        if (do_single)
            next_pair_state = PAIR_IDLE;
    end

    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wdt_clear_o <= 1'b0;
            pair_state  <= PAIR_IDLE;
        end
        else
        begin
            wdt_clear_o <= wdt_clr;
            pair_state  <= next_pair_state;
        end
    end

    always @*
        preclear_pending_o = (pair_state != PAIR_IDLE);

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    always @*
    begin
        // Hold by default: bit clear and a lone half leave flags alone
        next_timeout_flag   = timeout_flag_o;
        next_powerdown_flag = powerdown_flag_o;
        if (wdt_clr)
        begin
            next_timeout_flag   = `FLAG_CLEAR;
            next_powerdown_flag = `FLAG_CLEAR;
        end
        // Set wins over a same-cycle clear so a fresh event is never lost
        if (timeout_set_i)
            next_timeout_flag = 1'b1;
        if (powerdown_set_i)
            next_powerdown_flag = 1'b1;
    end

    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            timeout_flag_o   <= `FLAG_RESET;
            powerdown_flag_o <= `FLAG_RESET;
        end
        else
        begin
            timeout_flag_o   <= next_timeout_flag;
            powerdown_flag_o <= next_powerdown_flag;
        end
    end

endmodule
`default_nettype wire

//--- dv/bitclr_wdt_checker.sv
// Assertion checker for bitclr_wdt_exec
`timescale 1ns/1ps
`default_nettype none
`include "bitclr_wdt_regs.vh"
module bitclr_wdt_checker
(
    // Watched ports
    input wire       sys_clk_i, rst_b_i, exec_i, timeout_set_i, powerdown_set_i,
    input wire [2:0] op_i, bit_sel_i,
    input wire [7:0] mem_rdata_i, mem_wdata_o,
    input wire       mem_we_o, wdt_clear_o, timeout_flag_o, powerdown_flag_o,
    input wire       preclear_pending_o
);
    // ----------------
    // Properties
    // ----------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire       bc = exec_i && op_i == `OP_BIT_CLEAR;
    wire       sc = exec_i && op_i == `OP_WDT_CLEAR;
    wire       pre = exec_i && op_i inside {`OP_WDT_PRE_FIRST, `OP_WDT_PRE_SECND};
    // Flag sets excluded: set wins over clear, clear checked only otherwise
    wire       calm = !timeout_set_i && !powerdown_set_i;
    wire [1:0] fl = {timeout_flag_o, powerdown_flag_o};
    bit_clr_a: assert property (bc |=> mem_we_o && mem_wdata_o ==
        ($past(mem_rdata_i) & ~(8'h01 << $past(bit_sel_i)))) else $error("bit clear");
    we_cause_a: assert property (mem_we_o |-> $past(bc)) else $error("write");
    wdt_one_a: assert property (sc |=> wdt_clear_o) else $error("clear");
    one_flags_a: assert property (sc && calm |=> fl == 2'h0) else $error("flags");
    clr_cause_a: assert property (wdt_clear_o |->
        $past(sc || pre && preclear_pending_o)) else $error("stray clear");
    pair_flags_a: assert property (pre && calm |=>
        (wdt_clear_o ? fl == 2'h0 : $stable(fl))) else $error("pair flags");
    bc_flags_a: assert property (bc && calm |=> $stable(fl)) else $error("flags");
    cover property (bc);
    cover property (sc);
    cover property (pre && preclear_pending_o ##1 wdt_clear_o);
endmodule
bind bitclr_wdt_exec bitclr_wdt_checker u_bitclr_wdt_checker (.*);
`default_nettype wire

//--- dv/tb_top.sv
// Bench for bitclr_wdt_exec
`timescale 1ns/1ps
`default_nettype none
`include "bitclr_wdt_regs.vh"
module tb_top;
    // ----------------
    // Stimulus and checks
    // ----------------
    logic       clk = 0, rst_b = 0, ex = 0, ts = 0, ps = 0;
    logic [2:0] op = 0, sel = 0;
    logic [7:0] rd = 0;
    wire        we, wc, tf, pf, pnd;
    wire  [7:0] wd;
    int         miscompares = 0, n_checks = 0, cyc = 0;
    always #5 clk = ~clk;
    bitclr_wdt_exec u_bitclr_wdt_exec (.sys_clk_i(clk), .rst_b_i(rst_b), .exec_i(ex),
        .op_i(op), .bit_sel_i(sel), .mem_rdata_i(rd), .timeout_set_i(ts),
        .powerdown_set_i(ps), .mem_we_o(we), .mem_wdata_o(wd), .wdt_clear_o(wc),
        .timeout_flag_o(tf), .powerdown_flag_o(pf), .preclear_pending_o(pnd));
    task give_verdict;
        $display("checks %0d bad %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, s, e);
        end
    endtask
    // One instruction; answer settled after the next edge
    task go(input logic [2:0] o, input logic [2:0] s, input logic [7:0] d);
        @(posedge clk) #1 {ex, op, sel, rd} = {1'b1, o, s, d};
        @(posedge clk) #1 ex = 0;
    endtask
    task setf;
        @(posedge clk) #1 {ts, ps} = 2'h3;
        @(posedge clk) #1 {ts, ps} = 2'h0;
    endtask
    task t_bitclr;
        setf;
        for (int i = 0; i < 8; i++)
        begin
            go(`OP_BIT_CLEAR, i, 8'hA5 | (8'h01 << i));
            chk(wd, 8'hA5 & ~(8'h01 << i));
            chk({we, wc, tf, pf}, 8'h0B);
        end
    endtask
    task t_single;
        setf;
        go(`OP_WDT_PRE_FIRST, 0, 0);
        go(`OP_WDT_CLEAR, 0, 0);
        chk({we, wc, tf, pf, pnd}, 8'h08);
    endtask
    // Flag event in the clear's own cycle survives; unknown op does nothing
    task t_race;
        @(posedge clk) #1 {ex, op, ts, ps} = {1'b1, 3'(`OP_WDT_CLEAR), 2'h3};
        @(posedge clk) #1 {ex, ts, ps} = 3'h0;
        chk({wc, tf, pf}, 8'h07);
        go(3'h7, 0, 8'h00);
        chk({we, wc, tf, pf, pnd}, 8'h06);
    endtask
    // Repeat of one half and a foreign op between must not clear
    task t_pair(input logic [2:0] a, input logic [2:0] b);
        setf;
        go(a, 0, 0);
        chk({wc, tf, pf, pnd}, 8'h07);
        go(`OP_BIT_CLEAR, 0, 8'h01);
        go(a, 0, 0);
        chk({wc, tf, pf, pnd}, 8'h07);
        go(b, 0, 0);
        chk({wc, tf, pf, pnd}, 8'h08);
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        #1 rst_b = 1;
        chk({we, wc, tf, pf, pnd} | wd, 8'h00);
        t_bitclr;
        t_single;
        t_race;
        t_pair(`OP_WDT_PRE_FIRST, `OP_WDT_PRE_SECND);
        t_pair(`OP_WDT_PRE_SECND, `OP_WDT_PRE_FIRST);
        give_verdict;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 500)
        begin
            miscompares++;
            give_verdict;
        end
    end
endmodule
`default_nettype wire
